// >>> logic/codec_map.svh
`ifndef CODEC_MAP_SVH
`define CODEC_MAP_SVH

// Control frame layout
`define FRAME_BITS      16
`define FRM_ADDR_LSB    12
`define FRM_RW_BIT      11
`define FRM_RES_BIT     10

// Register addresses
`define ADDR_DAC1       4'h0
`define ADDR_DAC2       4'h1
`define ADDR_VOL_L1     4'h2
`define ADDR_VOL_R1     4'h3
`define ADDR_VOL_L2     4'h4
`define ADDR_VOL_R2     4'h5
`define ADDR_VOL_L3     4'h6
`define ADDR_VOL_R3     4'h7
`define ADDR_RSVD8      4'h8
`define ADDR_RSVD9      4'h9
`define ADDR_PEAK_L     4'ha
`define ADDR_PEAK_R     4'hb
`define ADDR_ADC1       4'hc
`define ADDR_ADC2       4'hd
`define ADDR_ADC3       4'he
`define ADDR_RSVDF      4'hf

// Writable bits per register
`define MASK_DAC1       10'h3ff
`define MASK_DAC2       10'h13f
`define MASK_VOL        10'h3ff
`define MASK_ADC1       10'h1c0
`define MASK_ADC2       10'h3fb
`define MASK_ADC3       10'h0e0

// Reset values and peak floor
`define RST_CTRL        10'h000
`define RST_VOL         10'h3ff
`define PEAK_RST        6'h00
`define PEAK_FLOOR      6'h3f

// Peak field position in the data field
`define PEAK_DATA_LSB   4

// Link edge on which read data is loaded
`define RESP_LOAD_CNT   5'h05

// Clock dividers and cascade length
`define AUX_DIV_BITS    9
`define AUX_BCLK_BIT    2
`define AUX_LR_BIT      8
`define TDM_BITS        256

`endif

// >>> logic/codec_pkg.sv
package codec_pkg;

	typedef enum logic [2:0] {
		FMT_I2S     = 3'h0,
		FMT_RIGHT   = 3'h1,
		FMT_DSP     = 3'h2,
		FMT_LEFT    = 3'h3,
		FMT_PACK256 = 3'h4,
		FMT_PACK128 = 3'h5,
		FMT_AUX256  = 3'h6,
		FMT_AUX512  = 3'h7
	} serial_fmt_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_EXEC = 2'h1,
		ST_RESP = 2'h3
	} ctl_state_t;

	typedef struct packed {
		logic [3:0] addr;
		logic       rd;
		logic       res;
		logic [9:0] data;
	} ctl_frame_t;

	typedef struct packed {
		logic [1:0] deemph;
		logic [2:0] fmt;
		logic [1:0] width;
		logic       powerDown;
		logic [1:0] rate;
	} dac_setup_t;

	typedef struct packed {
		logic       rsvd9;
		logic       replicate;
		logic [1:0] rsvd;
		logic [5:0] mute;
	} dac_copy_t;

	typedef struct packed {
		logic       rsvd9;
		logic       highPass;
		logic       powerDown;
		logic       rate96;
		logic [5:0] rsvd;
	} adc_setup_t;

	typedef struct packed {
		logic        auxMaster;
		serial_fmt_t fmt;
		logic [1:0]  width;
		logic        auxData;
		logic        rsvd;
		logic [1:0]  mute;
	} adc_format_t;

	typedef struct packed {
		logic [1:0] rsvd;
		logic [1:0] scale;
		logic       peakEn;
		logic [4:0] test;
	} clk_meter_t;

endpackage

// >>> logic/peak_tracker.sv
`timescale 1ns/1ps
`include "codec_map.svh"

module peak_tracker #(
	parameter int SW = 24
) (
	// System
	input  wire logic          clk,
	input  wire logic          rst_n,
	// Samples
	input  wire logic          enable,
	input  wire logic          sampleValid,
	input  wire logic [SW-1:0] sample,
	// Readback
	input  wire logic          clear,
	output logic [5:0]         peak
);

	logic [5:0] peak_q;
	logic       held_q;
	logic [5:0] newAtt;
	logic       take;

	function automatic logic [2:0] step_of(input logic [2:0] f);
		case (f)
			3'h0: return 3'h0;
			3'h1: return 3'h1;
			3'h2: return 3'h2;
			3'h3: return 3'h3;
			3'h4: return 3'h4;
			3'h5: return 3'h4;
			3'h6: return 3'h5;
			default: return 3'h5;
		endcase
	endfunction

	// Octave gives 6 dB, top mantissa bits refine it to about 1 dB
	function automatic logic [5:0] att_of(input logic [SW-1:0] s);
		logic [SW-1:0] mag;
		logic [SW-1:0] norm;
		int            pos;
		int            att;
		mag = s[SW-1] ? (~s + 1'b1) : s;
		pos = -1;
		for (int i = 0; i < SW - 1; i++) begin
			if (mag[i])
				pos = i;
		end
		if (mag[SW-1])
			return 6'h00;
		if (pos < 0)
			return `PEAK_FLOOR;
		norm = mag << (SW - 2 - pos);
		att = 6 * (SW - 1 - pos) - int'(step_of(norm[SW-3:SW-5]));
		if (att > 63)
			att = 63;
		if (att < 0)
			att = 0;
		return att[5:0];
	endfunction

	assign newAtt = att_of(sample);
	// Lower attenuation means louder
	assign take = enable && sampleValid &&
		(clear || !held_q || newAtt < peak_q);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			peak_q <= `PEAK_RST;
			held_q <= 1'b0;
		end else if (clear) begin
			// Sample in the clearing cycle survives
			peak_q <= take ? newAtt : `PEAK_RST;
			held_q <= take;
		end else if (take) begin
			peak_q <= newAtt;
			held_q <= 1'b1;
		end
	end

	assign peak = peak_q;

endmodule

// >>> logic/spi_frame_link.sv
`timescale 1ns/1ps
`include "codec_map.svh"

module spi_frame_link #(
	parameter int FW = `FRAME_BITS
) (
	// Link pins
	input  wire logic          sclk,
	input  wire logic          csN,
	input  wire logic          mosi,
	input  wire logic          rst_n,
	output logic               miso,
	output logic               misoOe,
	// To core domain
	output logic [FW-1:0]      frame,
	output logic               reqTog,
	// From core domain
	input  wire logic          respTog,
	input  wire logic [9:0]    respData
);

	logic          frameClr;
	logic [4:0]    cnt_q;
	logic [FW-1:0] sh_q;
	logic          respS1_q;
	logic          respS2_q;
	logic          respSeen_q;
	logic [9:0]    out_q;

	// Link clock may stop, so the frame's own select ends it
	assign frameClr = csN | ~rst_n;

	always_ff @(posedge sclk or posedge frameClr) begin
		if (frameClr) begin
			cnt_q  <= 5'h00;
			misoOe <= 1'b0;
		end else begin
			cnt_q  <= cnt_q + 5'h01;
			misoOe <= 1'b1;
		end
	end

	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			sh_q   <= '0;
			frame  <= '0;
			reqTog <= 1'b0;
		end else if (!csN) begin
			sh_q <= {sh_q[FW-2:0], mosi};
			if (cnt_q == 5'(FW - 1)) begin
				frame  <= {sh_q[FW-2:0], mosi};
				reqTog <= ~reqTog;
			end
		end
	end

	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			respS1_q <= 1'b0;
			respS2_q <= 1'b0;
		end else begin
			respS1_q <= respTog;
			respS2_q <= respS1_q;
		end
	end

	// Read data of one frame goes out in the low bits of the next
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			miso       <= 1'b0;
			out_q      <= 10'h000;
			respSeen_q <= 1'b0;
		end else if (!csN) begin
			if (cnt_q == `RESP_LOAD_CNT) begin
				if (respS2_q != respSeen_q) begin
					miso       <= respData[9];
					out_q      <= {respData[8:0], 1'b0};
					respSeen_q <= respS2_q;
				end else begin
					miso  <= 1'b0;
					out_q <= 10'h000;
				end
			end else if (cnt_q == 5'h00) begin
				miso  <= 1'b0;
				out_q <= 10'h000;
			end else begin
				miso  <= out_q[9];
				out_q <= {out_q[8:0], 1'b0};
			end
		end
	end

endmodule

// >>> logic/codec_control_register_bank.sv
`timescale 1ns/1ps
`include "codec_map.svh"
// Notes on behaviour
// - 16-bit frame: address, read bit, reserved, data
// - Keep per-channel loudest result as 6-bit attenuation
// - Reading a peak register clears it
// - Peak in top six data bits, low four zero
// - Peak capture only while meter enable set
// - Peaks at addresses 1010 and 1011, read only
// - ADC setup bit 6 picks 48 or 96 kHz
// - ADC setup bit 7 powers down digital ADC
// - Power-down affects digital section only
// - ADC setup bit 8 enables high-pass filter
// - ADC format bits 5..4 set word width
// - ADC format bits 8..6 select serial format
// - Aux master drives aux clocks, slave releases; code drives them only in FMT_AUX256/FMT_AUX512
// - Clock scale bits 7..6 set internal clock
// - DAC setup bits 9..8 select de-emphasis
// - DAC setup bits 7..5 select input format
// - DAC setup bits 4..3 set word width
// - DAC setup bit 2 powers down DAC digital
// - DAC setup bits 1..0 select sample rate
// - Copy bit sends pair A data everywhere
// - Six ten-bit linear volume levels
// - Cascade uses auxiliary 512 on both devices
// - Master device makes cascade frame and bit clock
// - 256-bit shift register swaps ADC for DAC
// - Chain input shifts through toward host
module codec_control_register_bank #(
	parameter int SAMPLE_W = 24,
	parameter int TDM_W    = `TDM_BITS
) (
	// System
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// Serial control link
	input  wire logic                  ctlSclk,
	input  wire logic                  ctlCsN,
	input  wire logic                  ctlMosi,
	output logic                       ctlMiso,
	output logic                       ctlMisoOe,
	// ADC results
	input  wire logic                  adcValid,
	input  wire logic [SAMPLE_W-1:0]   adcLeft,
	input  wire logic [SAMPLE_W-1:0]   adcRight,
	// Converter settings
	output codec_pkg::dac_setup_t      dacSetup,
	output codec_pkg::dac_copy_t       dacCopy,
	output logic [5:0][9:0]            dacLevel,
	output codec_pkg::adc_setup_t      adcSetup,
	output codec_pkg::adc_format_t     adcFormat,
	output codec_pkg::clk_meter_t      clkMeter,
	// Auxiliary clock pins
	output logic                       auxBclkOut,
	output logic                       auxBclkOe,
	output logic                       auxLrclkOut,
	output logic                       auxLrclkOe,
	// Cascade port
	input  wire logic                  tdmSlaveStrap,
	input  wire logic                  tdmBclkIn,
	input  wire logic                  tdmFsyncIn,
	input  wire logic                  tdmDataIn,
	input  wire logic [TDM_W-1:0]      adcFrame,
	output logic                       tdmBclkOut,
	output logic                       tdmFsyncOut,
	output logic                       tdmClkOe,
	output logic                       tdmDataOut,
	output logic [TDM_W-1:0]           dacFrame,
	output logic                       dacFrameValid
);

	localparam int CW = $clog2(TDM_W);
	localparam logic [CW-1:0] TDM_LAST = CW'(TDM_W - 1);

	codec_pkg::ctl_state_t  state_q;
	codec_pkg::ctl_frame_t  frame_q;
	codec_pkg::dac_setup_t  dacSetup_q;
	codec_pkg::dac_copy_t   dacCopy_q;
	codec_pkg::adc_setup_t  adcSetup_q;
	codec_pkg::adc_format_t adcFormat_q;
	codec_pkg::clk_meter_t  clkMeter_q;
	logic [5:0][9:0]        level_q;
	logic [15:0]            linkFrame;
	logic                   linkReqTog;
	logic                   reqS1_q;
	logic                   reqS2_q;
	logic                   reqSeen_q;
	logic                   newFrame;
	logic                   respTog_q;
	logic [9:0]             respData_q;
	logic                   doWrite;
	logic                   doRead;
	logic [5:0]             peakL;
	logic [5:0]             peakR;
	logic                   clrL;
	logic                   clrR;

	spi_frame_link #(
		.FW(`FRAME_BITS)
	) u_link (
		.sclk    (ctlSclk),
		.csN     (ctlCsN),
		.mosi    (ctlMosi),
		.rst_n   (rst_n),
		.miso    (ctlMiso),
		.misoOe  (ctlMisoOe),
		.frame   (linkFrame),
		.reqTog  (linkReqTog),
		.respTog (respTog_q),
		.respData(respData_q)
	);

	// Frame word is held by the link until its next frame ends
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reqS1_q <= 1'b0;
			reqS2_q <= 1'b0;
		end else begin
			reqS1_q <= linkReqTog;
			reqS2_q <= reqS1_q;
		end
	end

	assign newFrame = reqS2_q != reqSeen_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q   <= codec_pkg::ST_IDLE;
			reqSeen_q <= 1'b0;
			frame_q   <= '0;
		end else begin
			case (state_q)
				codec_pkg::ST_IDLE: begin
					if (newFrame) begin
						frame_q   <= codec_pkg::ctl_frame_t'(linkFrame);
						reqSeen_q <= reqS2_q;
						state_q   <= codec_pkg::ST_EXEC;
					end
				end
				codec_pkg::ST_EXEC: state_q <= codec_pkg::ST_RESP;
				codec_pkg::ST_RESP: state_q <= codec_pkg::ST_IDLE;
				default: state_q <= codec_pkg::ST_IDLE;
			endcase
		end
	end

	assign doWrite = state_q == codec_pkg::ST_EXEC && !frame_q.rd;
	assign doRead  = state_q == codec_pkg::ST_EXEC && frame_q.rd;

	function automatic logic [9:0] mask_of(input logic [3:0] a);
		case (a)
			`ADDR_DAC1: return `MASK_DAC1;
			`ADDR_DAC2: return `MASK_DAC2;
			`ADDR_VOL_L1, `ADDR_VOL_R1, `ADDR_VOL_L2,
			`ADDR_VOL_R2, `ADDR_VOL_L3, `ADDR_VOL_R3: return `MASK_VOL;
			`ADDR_ADC1: return `MASK_ADC1;
			`ADDR_ADC2: return `MASK_ADC2;
			`ADDR_ADC3: return `MASK_ADC3;
			default:    return 10'h000;
		endcase
	endfunction

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dacSetup_q  <= `RST_CTRL;
			dacCopy_q   <= `RST_CTRL;
			adcSetup_q  <= `RST_CTRL;
			adcFormat_q <= `RST_CTRL;
			clkMeter_q  <= `RST_CTRL;
			for (int i = 0; i < 6; i++) begin
				level_q[i] <= `RST_VOL;
			end
		end else if (doWrite) begin
			case (frame_q.addr)
				`ADDR_DAC1: dacSetup_q <=
					frame_q.data & mask_of(frame_q.addr);
				`ADDR_DAC2: dacCopy_q <=
					frame_q.data & mask_of(frame_q.addr);
				`ADDR_VOL_L1, `ADDR_VOL_R1, `ADDR_VOL_L2,
				`ADDR_VOL_R2, `ADDR_VOL_L3, `ADDR_VOL_R3: begin
					level_q[frame_q.addr - `ADDR_VOL_L1] <=
						frame_q.data;
				end
				`ADDR_ADC1: adcSetup_q <=
					frame_q.data & mask_of(frame_q.addr);
				`ADDR_ADC2: adcFormat_q <=
					frame_q.data & mask_of(frame_q.addr);
				`ADDR_ADC3: clkMeter_q <=
					frame_q.data & mask_of(frame_q.addr);
				default: ;
			endcase
		end
	end

	function automatic logic [9:0] read_value(input logic [3:0] a);
		case (a)
			`ADDR_DAC1:   return dacSetup_q;
			`ADDR_DAC2:   return dacCopy_q;
			`ADDR_VOL_L1, `ADDR_VOL_R1, `ADDR_VOL_L2,
			`ADDR_VOL_R2, `ADDR_VOL_L3, `ADDR_VOL_R3:
				return level_q[a - `ADDR_VOL_L1];
			`ADDR_PEAK_L: return {peakL, 4'h0};
			`ADDR_PEAK_R: return {peakR, 4'h0};
			`ADDR_ADC1:   return adcSetup_q;
			`ADDR_ADC2:   return adcFormat_q;
			`ADDR_ADC3:   return clkMeter_q;
			default:      return 10'h000;
		endcase
	endfunction

	// Writes get no answer; only reads toggle the response
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			respTog_q  <= 1'b0;
			respData_q <= 10'h000;
		end else begin
			if (doRead)
				respData_q <= read_value(frame_q.addr);
			if (state_q == codec_pkg::ST_RESP && frame_q.rd)
				respTog_q <= ~respTog_q;
		end
	end

	assign clrL = doRead && frame_q.addr == `ADDR_PEAK_L;
	assign clrR = doRead && frame_q.addr == `ADDR_PEAK_R;

	peak_tracker #(
		.SW(SAMPLE_W)
	) u_peak_left (
		.clk        (clk),
		.rst_n      (rst_n),
		.enable     (clkMeter_q.peakEn),
		.sampleValid(adcValid),
		.sample     (adcLeft),
		.clear      (clrL),
		.peak       (peakL)
	);

	peak_tracker #(
		.SW(SAMPLE_W)
	) u_peak_right (
		.clk        (clk),
		.rst_n      (rst_n),
		.enable     (clkMeter_q.peakEn),
		.sampleValid(adcValid),
		.sample     (adcRight),
		.clear      (clrR),
		.peak       (peakR)
	);

	// Power-down bits only reach digital logic
	assign dacSetup  = dacSetup_q;
	assign dacCopy   = dacCopy_q;
	assign dacLevel  = level_q;
	assign adcSetup  = adcSetup_q;
	assign adcFormat = adcFormat_q;
	assign clkMeter  = clkMeter_q;

	// Auxiliary clocks, from the internal clock
	logic                     auxMasterOn;
	logic [`AUX_DIV_BITS-1:0] auxDiv_q;

	assign auxMasterOn = adcFormat_q.auxMaster &&
		(adcFormat_q.fmt == codec_pkg::FMT_AUX256 ||
		 adcFormat_q.fmt == codec_pkg::FMT_AUX512);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			auxDiv_q    <= '0;
			auxBclkOut  <= 1'b0;
			auxLrclkOut <= 1'b0;
			auxBclkOe   <= 1'b0;
			auxLrclkOe  <= 1'b0;
		end else begin
			auxDiv_q    <= auxDiv_q + 1'b1;
			auxBclkOut  <= auxMasterOn && auxDiv_q[`AUX_BCLK_BIT];
			auxLrclkOut <= auxMasterOn && auxDiv_q[`AUX_LR_BIT];
			// Slave leaves both pins to the external converter
			auxBclkOe   <= auxMasterOn;
			auxLrclkOe  <= auxMasterOn;
		end
	end

	// Cascade shift register
	logic            strapS1_q;
	logic            strapS2_q;
	logic            tdmSlave_q;
	logic            bclkS1_q;
	logic            bclkS2_q;
	logic            bclkS3_q;
	logic            fsS1_q;
	logic            fsS2_q;
	logic            dinS1_q;
	logic            dinS2_q;
	logic            aux512;
	logic            tick;
	logic [CW-1:0]   tdmCnt_q;
	logic [TDM_W-1:0] sr_q;

	// Strap follows the pin through reset and freezes on release
	always_ff @(posedge clk) begin
		strapS1_q <= tdmSlaveStrap;
		strapS2_q <= strapS1_q;
		bclkS1_q  <= tdmBclkIn;
		bclkS2_q  <= bclkS1_q;
		bclkS3_q  <= bclkS2_q;
		fsS1_q    <= tdmFsyncIn;
		fsS2_q    <= fsS1_q;
		dinS1_q   <= tdmDataIn;
		dinS2_q   <= dinS1_q;
		if (!rst_n)
			tdmSlave_q <= strapS2_q;
	end

	assign aux512 = adcFormat_q.fmt == codec_pkg::FMT_AUX512;
	assign tick = aux512 && (tdmSlave_q ? (bclkS2_q && !bclkS3_q)
		: !tdmBclkOut);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tdmBclkOut    <= 1'b0;
			tdmFsyncOut   <= 1'b0;
			tdmClkOe      <= 1'b0;
			tdmDataOut    <= 1'b0;
			tdmCnt_q      <= '0;
			sr_q          <= '0;
			dacFrame      <= '0;
			dacFrameValid <= 1'b0;
		end else begin
			dacFrameValid <= 1'b0;
			tdmClkOe      <= !tdmSlave_q;
			tdmBclkOut    <= aux512 && !tdmSlave_q && !tdmBclkOut;
			if (!aux512) begin
				tdmCnt_q    <= '0;
				tdmFsyncOut <= 1'b0;
				tdmDataOut  <= 1'b0;
			end else if (tick) begin
				tdmFsyncOut <= !tdmSlave_q && tdmCnt_q == TDM_LAST;
				if (tdmCnt_q == TDM_LAST) begin
					dacFrame      <= {sr_q[TDM_W-2:0], dinS2_q};
					dacFrameValid <= 1'b1;
					sr_q          <= adcFrame;
					tdmDataOut    <= adcFrame[TDM_W-1];
					tdmCnt_q      <= '0;
				end else begin
					sr_q       <= {sr_q[TDM_W-2:0], dinS2_q};
					tdmDataOut <= sr_q[TDM_W-2];
					tdmCnt_q   <= (tdmSlave_q && fsS2_q) ? CW'(1)
						: tdmCnt_q + 1'b1;
				end
			end
		end
	end

	default clocking dcb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	chk_adc_setup_write: assert property (doWrite &&
		frame_q.addr == `ADDR_ADC1 |=> adcSetup_q ==
		($past(frame_q.data) & `MASK_ADC1))
		else $error("ADC setup write not stored");
	chk_copy_bit_write: assert property (doWrite &&
		frame_q.addr == `ADDR_DAC2 |=>
		dacCopy_q.replicate == $past(frame_q.data[8]))
		else $error("Copy bit not stored");
	chk_peak_low_zero: assert property (doRead &&
		frame_q.addr == `ADDR_PEAK_L |=> respData_q[3:0] == 4'h0 &&
		respData_q[9:4] == $past(peakL))
		else $error("Peak readback misplaced");
	chk_peak_read_clear: assert property (clrL && !adcValid |=>
		peakL == `PEAK_RST)
		else $error("Peak not cleared by read");
	chk_peak_frozen_off: assert property (!clkMeter_q.peakEn && !clrR
		|=> $stable(peakR))
		else $error("Peak moved while disabled");
	chk_rsvd_read_zero: assert property (doRead &&
		frame_q.addr inside {`ADDR_RSVD8, `ADDR_RSVD9, `ADDR_RSVDF}
		|=> respData_q == 10'h000)
		else $error("Reserved read not zero");
	chk_frame_sequence: assert property (state_q ==
		codec_pkg::ST_IDLE && newFrame |=> doWrite || doRead ##1
		state_q == codec_pkg::ST_RESP ##1
		state_q == codec_pkg::ST_IDLE)
		else $error("Frame sequence broken");
	chk_read_answer: assert property (doRead |-> ##2
		respTog_q != $past(respTog_q, 2))
		else $error("Read not answered");
	chk_aux_slave_off: assert property (!auxMasterOn [*2] |->
		!auxBclkOe && !auxLrclkOe && !auxBclkOut)
		else $error("Aux clocks driven as slave");
	chk_tdm_publish: assert property (dacFrameValid |->
		tdmCnt_q == '0 && $past(aux512))
		else $error("Cascade frame out of step");

	cov_peak_read: cover property (clrL ##2 respTog_q != $past(respTog_q));
	cov_level_write: cover property (doWrite &&
		frame_q.addr == `ADDR_VOL_L1);
	cov_aux_master: cover property ($rose(auxBclkOut));
	cov_tdm_frame: cover property (dacFrameValid);

endmodule

// >>> bench/spi_host_model.sv
`timescale 1ns/1ps

module spi_host_model (
	// Link pins
	output logic       sclk,
	output logic       csN,
	output logic       mosi,
	input  wire logic  miso,
	// Bench side
	output logic [9:0] rxData,
	output logic       rxDone
);
	initial begin
		sclk = 1'b0;
		csN = 1'b1;
		mosi = 1'b1;
		rxData = 10'h000;
		rxDone = 1'b0;
	end

	// Clock stands low outside frames; 12 ns period
	task automatic xfer(input codec_pkg::ctl_frame_t f);
		logic [15:0] rx;
		rx = 16'h0000;
		csN = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			mosi = f[i];
			#6 sclk = 1'b1;
			rx = {rx[14:0], miso};
			#6 sclk = 1'b0;
		end
		#6 csN = 1'b1;
		mosi = ~mosi;
		rxData = rx[9:0];
		rxDone = 1'b1;
		#2 rxDone = 1'b0;
		// Gap lets the core answer before the next frame
		#240;
	endtask
endmodule

// >>> bench/codec_control_register_bank_tb.sv
`timescale 1ns/1ps

module codec_control_register_bank_tb;
	logic                   clk = 1'b0;
	logic                   rst_n = 1'b0;
	logic                   sclk, csN, mosi, miso, rxDone, misoOe;
	logic [9:0]             rxData;
	logic                   adcValid = 1'b0;
	logic [23:0]            adcLeft = 24'h00_0000;
	logic [23:0]            adcRight = 24'h00_0000;
	codec_pkg::dac_setup_t  dacSetup;
	codec_pkg::dac_copy_t   dacCopy;
	logic [5:0][9:0]        dacLevel;
	codec_pkg::adc_setup_t  adcSetup;
	codec_pkg::adc_format_t adcFormat;
	codec_pkg::clk_meter_t  clkMeter;
	logic                   auxBclkOe, auxLrclkOe, tdmFsyncOut, tdmClkOe;
	int                     miscompares = 0;
	int                     n_compared = 0;
	int                     cycles = 0;
	logic [10:0]            expQ[$];
	logic [10:0]            pend = 11'h000;
	logic [31:0]            lfsr = 32'h0000_7f17;

	always #10 clk = ~clk;

	spi_host_model i_host (.sclk(sclk), .csN(csN), .mosi(mosi),
		.miso(miso), .rxData(rxData), .rxDone(rxDone));

	codec_control_register_bank i_dut (
		.clk(clk), .rst_n(rst_n), .ctlSclk(sclk), .ctlCsN(csN),
		.ctlMosi(mosi), .ctlMiso(miso), .ctlMisoOe(misoOe),
		.adcValid(adcValid), .adcLeft(adcLeft), .adcRight(adcRight),
		.dacSetup(dacSetup), .dacCopy(dacCopy), .dacLevel(dacLevel),
		.adcSetup(adcSetup), .adcFormat(adcFormat), .clkMeter(clkMeter),
		.auxBclkOut(), .auxBclkOe(auxBclkOe), .auxLrclkOut(),
		.auxLrclkOe(auxLrclkOe), .tdmSlaveStrap(1'b0), .tdmBclkIn(1'b0),
		.tdmFsyncIn(1'b0), .tdmDataIn(1'b0), .adcFrame({256{1'b0}}),
		.tdmBclkOut(), .tdmFsyncOut(tdmFsyncOut), .tdmClkOe(tdmClkOe),
		.tdmDataOut(), .dacFrame(), .dacFrameValid());

	function automatic logic [31:0] nextRand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Reserved bits and read-only places read back as zero
	function automatic logic [9:0] mask(input logic [3:0] a);
		case (a)
			4'h0: return 10'h3ff;
			4'h1: return 10'h13f;
			4'hc: return 10'h1c0;
			4'hd: return 10'h3fb;
			4'he: return 10'h0e0;
			default: return (a >= 4'h2 && a <= 4'h7) ? 10'h3ff : 10'h000;
		endcase
	endfunction

	function automatic logic [9:0] portVal(input logic [3:0] a);
		case (a)
			4'h0: return dacSetup;
			4'h1: return dacCopy;
			4'hc: return adcSetup;
			4'hd: return adcFormat;
			4'he: return clkMeter;
			default: return (a >= 4'h2 && a <= 4'h7) ? dacLevel[a - 4'h2] : 10'h000;
		endcase
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Answer to a read shows in the following frame
	task automatic frame(input logic [3:0] a, input logic rd,
			input logic [9:0] d, input logic [10:0] nxt);
		codec_pkg::ctl_frame_t f;
		f = '{addr: a, rd: rd, res: 1'b0, data: d};
		expQ.push_back(pend);
		pend = nxt;
		i_host.xfer(f);
	endtask

	task automatic wr(input logic [3:0] a, input logic [9:0] d);
		frame(a, 1'b0, d, 11'h000);
	endtask

	task automatic rd(input logic [3:0] a, input logic [9:0] e);
		frame(a, 1'b1, 10'h000, {1'b1, e});
	endtask

	task automatic sample(input logic [23:0] l, input logic [23:0] r);
		@(negedge clk);
		adcValid = 1'b1;
		adcLeft = l;
		adcRight = r;
		@(negedge clk);
		adcValid = 1'b0;
		lfsr = nextRand(lfsr);
		adcLeft = lfsr[23:0];
		adcRight = lfsr[31:8];
	endtask

	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	always @(posedge rxDone) begin
		logic [10:0] e;
		e = expQ.pop_front();
		if (e[10])
			check(rxData, e[9:0]);
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 10000) begin
			miscompares++;
			test_done();
		end
	end

	initial begin
		logic [9:0] r;
		int n;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		for (int a = 0; a < 16; a++)
			rd(a[3:0], mask(a[3:0]) == 10'h3ff && a > 1 ? 10'h3ff : 10'h000);
		for (int a = 0; a < 16; a++) begin
			lfsr = nextRand(lfsr);
			r = lfsr[9:0];
			wr(a[3:0], r);
			check(portVal(a[3:0]), r & mask(a[3:0]));
			rd(a[3:0], r & mask(a[3:0]));
		end
		// Every code of the DAC setup fields, clock scale, ADC setup bits 8..6, ADC serial format and width
		for (int i = 0; i < 8; i++) begin
			r = {i[1:0], i[2:0], i[1:0], i[0], i[1:0]};
			wr(4'h0, r);
			check(dacSetup, r);
			wr(4'he, {2'b00, i[1:0], 6'h00});
			check(clkMeter.scale, i[1:0]);
			wr(4'hc, {1'b0, i[2:0], 6'h00});
			check(adcSetup, {1'b0, i[2:0], 6'h00});
			wr(4'hd, {1'b1, i[2:0], i[1:0], 4'h0});
			check(adcFormat.fmt, i[2:0]);
			check({auxBclkOe, auxLrclkOe}, i > 5 ? 2'b11 : 2'b00);
		end
		check(tdmClkOe, 1'b1);
		@(posedge tdmFsyncOut);
		@(negedge clk);
		n = cycles;
		@(posedge tdmFsyncOut);
		@(negedge clk);
		check(cycles - n, 512);
		wr(4'hd, 10'h1c0);
		check({auxBclkOe, auxLrclkOe}, 2'b00);
		// Peak meter: off, then on, loudest kept, read clears
		wr(4'he, 10'h000);
		sample(24'h40_0000, 24'h00_0001);
		rd(4'ha, 10'h000);
		rd(4'hb, 10'h000);
		wr(4'he, 10'h020);
		sample(24'h10_0000, 24'h00_0001);
		sample(24'h40_0000, 24'h00_0001);
		sample(24'h10_0000, 24'h00_0001);
		rd(4'ha, 10'h060);
		rd(4'hb, 10'h3f0);
		rd(4'ha, 10'h000);
		rd(4'hb, 10'h000);
		rd(4'h0, 10'h000);
		check(misoOe, 1'b0);
		test_done();
	end
endmodule
